// ### common/ogs_pkg.sv
// Shared types, widths and reset values for the output gate and sync select
package ogs_pkg;

   // Sample width of the generated waveform and of the offset level
   localparam int OGS_DATA_W = 16;
   // Width of the intermediate mirror arithmetic (two guard bits)
   localparam int OGS_WIDE_W = OGS_DATA_W + 2;
   // Saturation limits of a signed sample, held at the wide width
   localparam logic signed [OGS_WIDE_W-1:0] OGS_SAT_MAX = 18'sh07fff;
   localparam logic signed [OGS_WIDE_W-1:0] OGS_SAT_MIN = 18'sh38000;
   // Reset values of the registered outputs
   localparam logic [OGS_DATA_W-1:0] OGS_CHAN_RST = 16'h0000;
   localparam logic OGS_SYNC_RST = 1'h0;
   localparam logic OGS_ROUTE_RST = 1'h0;

   // Channel output mode
   typedef enum logic [0:0] {
      OGS_OUT_NORMAL,
      OGS_OUT_GATED
   } ogs_out_mode_t;

   // Sync pin mode: normal, raw waveform, flag position
   typedef enum logic [1:0] {
      OGS_SYNC_NORMAL,
      OGS_SYNC_RAW,
      OGS_SYNC_FLAG
   } ogs_sync_mode_t;

   // Source chosen to drive the sync pin
   typedef enum logic [3:0] {
      OGS_SRC_WAVE,
      OGS_SRC_BURST_ENV,
      OGS_SRC_SWEEP_ENV,
      OGS_SRC_MOD,
      OGS_SRC_WAVE_IN_BURST,
      OGS_SRC_FLAG_SAMPLE,
      OGS_SRC_FLAG_CYCLE,
      OGS_SRC_FLAG_FREQ
   } ogs_src_t;

   // Operating conditions of the channel
   typedef struct packed {
      logic burst_on;          // Burst running
      logic sweep_on;          // Sweep running
      logic mod_on;            // Modulation running
      logic mod_ext;           // Modulation source is external
      logic unmodulated_run;   // Plain continuous run
      logic wave_user;         // waveform_shape_select picks a user table
      logic modsh_user;        // modulator_shape_select picks a user table
   } ogs_cond_t;

   // One-bit sync candidates from the generator, all on clk_sys
   typedef struct packed {
      logic burst_env;         // Burst envelope
      logic sweep_env;         // Sweep envelope
      logic mod_sig;           // Modulating signal square
      logic wave_sig;          // Waveform square
      logic flag_sample;       // Flag sample index reached
      logic flag_cycle;        // Flag burst cycle reached
      logic flag_freq;         // Flag sweep frequency reached
   } ogs_marks_t;

   // Mirror a sample about the offset: 2*offset - sample, saturated
   function automatic logic [OGS_DATA_W-1:0] ogs_mirror(
      input logic signed [OGS_DATA_W-1:0] smp,
      input logic signed [OGS_DATA_W-1:0] ofs);
      logic signed [OGS_WIDE_W-1:0] t;
      t = ({{2{ofs[OGS_DATA_W-1]}}, ofs} <<< 1)
          - {{2{smp[OGS_DATA_W-1]}}, smp};
      if (t > OGS_SAT_MAX) begin
         t = OGS_SAT_MAX;
      end else if (t < OGS_SAT_MIN) begin
         t = OGS_SAT_MIN;
      end
      return t[OGS_DATA_W-1:0];
   endfunction

endpackage

// ### rtl/ogs_sync2.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module ogs_sync2 (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);

   // First stage, read only by the second stage
   logic meta_r;

   // Both stages clear on reset so the level starts inactive
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= 1'h0;
         sync_out <= 1'h0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // ogs_sync2

`default_nettype wire

// ### rtl/ogs_sync_sel.sv
// Combinational choice of the sync pin source per mode and condition
`timescale 1ns/1ps
`default_nettype none

module ogs_sync_sel (
   input wire ogs_pkg::ogs_sync_mode_t mode,
   input wire ogs_pkg::ogs_cond_t cond,
   input wire ogs_pkg::ogs_marks_t marks,
   output ogs_pkg::ogs_src_t src,
   output logic level
);

   // Helper conditions
   wire logic mod_int = cond.mod_on && !cond.mod_ext;
   wire logic mod_ext = cond.mod_on && cond.mod_ext;
   wire logic any_user = cond.wave_user || cond.modsh_user;

   // Normal mode: envelopes first, then internal modulator
   wire ogs_pkg::ogs_src_t src_norm =
      cond.burst_on ? ogs_pkg::OGS_SRC_BURST_ENV :
      cond.sweep_on ? ogs_pkg::OGS_SRC_SWEEP_ENV :
      mod_int       ? ogs_pkg::OGS_SRC_MOD :
                      ogs_pkg::OGS_SRC_WAVE;

   // Raw mode: user table under burst or sweep shows the flag sample
   wire ogs_pkg::ogs_src_t src_raw =
      ((cond.burst_on || cond.sweep_on) && cond.wave_user) ?
         ogs_pkg::OGS_SRC_FLAG_SAMPLE :
      cond.burst_on ? ogs_pkg::OGS_SRC_WAVE_IN_BURST :
                      ogs_pkg::OGS_SRC_WAVE;

   // Flag mode: a running burst or sweep outranks the sample flag
   wire logic flag_smp =
      (cond.unmodulated_run && cond.wave_user) ||
      (mod_int && any_user) ||
      (mod_ext && cond.wave_user);
   wire ogs_pkg::ogs_src_t src_flag =
      cond.burst_on ? ogs_pkg::OGS_SRC_FLAG_CYCLE :
      cond.sweep_on ? ogs_pkg::OGS_SRC_FLAG_FREQ :
      flag_smp      ? ogs_pkg::OGS_SRC_FLAG_SAMPLE :
      (mod_ext && !any_user) ? ogs_pkg::OGS_SRC_MOD :
                      ogs_pkg::OGS_SRC_WAVE;

   // Mode select; an unused mode code falls back to the normal mode
   assign src = (mode == ogs_pkg::OGS_SYNC_RAW)  ? src_raw :
                (mode == ogs_pkg::OGS_SYNC_FLAG) ? src_flag : src_norm;

   // Level of the chosen candidate
   always_comb begin
      unique case (src)
         ogs_pkg::OGS_SRC_BURST_ENV:     level = marks.burst_env;
         ogs_pkg::OGS_SRC_SWEEP_ENV:     level = marks.sweep_env;
         ogs_pkg::OGS_SRC_MOD:           level = marks.mod_sig;
         ogs_pkg::OGS_SRC_WAVE_IN_BURST:
            level = marks.wave_sig && marks.burst_env;
         ogs_pkg::OGS_SRC_FLAG_SAMPLE:   level = marks.flag_sample;
         ogs_pkg::OGS_SRC_FLAG_CYCLE:    level = marks.flag_cycle;
         ogs_pkg::OGS_SRC_FLAG_FREQ:     level = marks.flag_freq;
         default:                        level = marks.wave_sig;
      endcase
   end

endmodule // ogs_sync_sel

`default_nettype wire

// ### rtl/ogs_output_gate.sv
// Channel output gating, polarity mirror and sync pin driver
//
// Contract
// R1: Gated mode passes waveform only while trigger asserted
// R2: Generator keeps running while gate blocks output
// R3: Gate touches routing only, never relay or termination
// R4: Inverted polarity mirrors waveform about the offset
// R5: Sync pin ignores the channel polarity setting
// R6: Disabled sync holds pin low; enabled after reset
// R7: Normal sync: burst, sweep, internal modulator, else waveform
// R8: Raw sync, burst/sweep, user table: flag sample
// R9: Raw sync, burst, no table: waveform in burst
// R10: Flag sync, user table driving output: flag sample
// R11: Flag sync during burst marks flag cycle
// R12: Flag sync during sweep marks flag frequency
// R13: Flag sync, external modulation, no table: modulator
// R14: Setting changes act at next clock, glitch free
`timescale 1ns/1ps
`default_nettype none

module ogs_output_gate (
   input wire logic clk_sys,
   input wire logic rst_n,
   // Asynchronous trigger input pin, high means asserted
   input wire logic trig_pin,
   // Settings, static levels from control logic on clk_sys
   input wire ogs_pkg::ogs_out_mode_t out_mode,
   input wire logic pol_invert,
   input wire logic sync_off,
   input wire ogs_pkg::ogs_sync_mode_t sync_mode,
   // Operating conditions and sync candidates from the generator
   input wire ogs_pkg::ogs_cond_t cond,
   input wire ogs_pkg::ogs_marks_t marks,
   // Generator sample and offset level, signed two's complement
   input wire logic [ogs_pkg::OGS_DATA_W-1:0] wave_in,
   input wire logic [ogs_pkg::OGS_DATA_W-1:0] offset_in,
   // Conditioned channel sample towards the converter
   output logic [ogs_pkg::OGS_DATA_W-1:0] chan_out_r,
   // High while the waveform is routed to the channel
   output logic chan_route_r,
   // Sync pin level
   output logic sync_pin_r
);

   // Trigger after two flip-flops
   logic trig_q;
   // Sync selector answer
   ogs_pkg::ogs_src_t sync_src;
   logic sync_level;

   // The trigger arrives from a connector, so it is retimed before use
   ogs_sync2 u_trig_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(trig_pin),
      .sync_out(trig_q)
   );

   // Source choice for the sync pin, taken from the raw marks
   ogs_sync_sel u_sync_sel (
      .mode(sync_mode),
      .cond(cond),
      .marks(marks),
      .src(sync_src),
      .level(sync_level)
   );

   // Gate state: normal mode always routes, gated mode follows trigger
   wire logic gate_open =
      (out_mode == ogs_pkg::OGS_OUT_NORMAL) || trig_q; // R1

   // Mirrored sample about the offset; offset itself is not touched
   wire logic [ogs_pkg::OGS_DATA_W-1:0] wave_mirr =
      ogs_pkg::ogs_mirror(wave_in, offset_in); // R4

   // Polarity select, made before the gate so both act independently
   wire logic [ogs_pkg::OGS_DATA_W-1:0] wave_pol =
      pol_invert ? wave_mirr : wave_in; // R4

   // A blocked channel rests at the offset level rather than zero,
   // so opening the gate does not step the DC level
   wire logic [ogs_pkg::OGS_DATA_W-1:0] chan_nxt =
      gate_open ? wave_pol : offset_in; // R1

   // Sync pin: polarity never enters this path; disabled means low
   wire logic sync_nxt = !sync_off && sync_level; // R5 R6

   // Output data path. The generator is only observed here: nothing
   // feeds back to it, so a closed gate cannot pause or reset it.
   // Likewise there is no relay or termination control in this block.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         chan_out_r <= ogs_pkg::OGS_CHAN_RST;
         chan_route_r <= ogs_pkg::OGS_ROUTE_RST;
      end else begin
         chan_out_r <= chan_nxt; // R1 R2 R3
         chan_route_r <= gate_open; // R1
      end
   end

   // Sync pin flop. Registering it hides the decode hazards of the
   // selector when a setting changes, at a cost of one cycle latency.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync_pin_r <= ogs_pkg::OGS_SYNC_RST;
      end else begin
         sync_pin_r <= sync_nxt; // R6 R14
      end
   end

   // High once an edge has run out of reset. The release edge still
   // loads reset values, so checks started there would misfire.
   logic live_r;

   // Follows the reset input one edge late
   always_ff @(posedge clk_sys) begin
      live_r <= rst_n;
   end

   // Checks on the conditioned outputs, all on clk_sys
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n || !live_r);

   // Gated and idle trigger: channel shows the offset next cycle
   a_gate_blocks: assert property ( // R1
      (out_mode == ogs_pkg::OGS_OUT_GATED && !trig_q)
      |=> (chan_out_r == $past(offset_in) && !chan_route_r))
      else $error("gated channel not blocked");

   // Open gate, normal polarity: live sample passes unchanged
   a_gate_passes: assert property ( // R2
      (gate_open && !pol_invert)
      |=> (chan_out_r == $past(wave_in) && chan_route_r))
      else $error("open channel does not carry waveform");

   // Normal output mode always routes the channel
   a_gate_norm_route: assert property ( // R1
      (out_mode == ogs_pkg::OGS_OUT_NORMAL) |=> chan_route_r)
      else $error("normal mode channel not routed");

   // Gated mode with trigger asserted passes the live sample
   a_gate_trig_open: assert property ( // R1
      (out_mode == ogs_pkg::OGS_OUT_GATED && trig_q && !pol_invert)
      |=> (chan_route_r && chan_out_r == $past(wave_in)))
      else $error("triggered gate does not pass waveform");

   // Trigger reaches the gate through exactly two stages
   a_trig_retimed: assert property ( // R1
      ($past(rst_n) && $past(rst_n, 2)) |-> trig_q == $past(trig_pin, 2))
      else $error("trigger not retimed by two stages");

   // Inverted polarity mirrors about the offset
   a_pol_mirror: assert property ( // R4
      (gate_open && pol_invert)
      |=> chan_out_r == ogs_pkg::ogs_mirror($past(wave_in),
                                            $past(offset_in)))
      else $error("inverted sample not mirrored");

   // A sample at the offset level stays there when inverted
   a_offset_kept: assert property ( // R4
      (gate_open && pol_invert && wave_in == offset_in)
      |=> chan_out_r == $past(offset_in))
      else $error("inversion moved the offset level");

   // Disabled sync pin is low one cycle on and stays low
   a_sync_off_low: assert property ( // R6
      sync_off [*2] |-> !sync_pin_r ##1 !sync_pin_r)
      else $error("disabled sync pin not low");

   // Polarity change does not move the waveform sync
   a_sync_pol_free: assert property ( // R5
      (!sync_off && sync_src == ogs_pkg::OGS_SRC_WAVE)
      |=> sync_pin_r == $past(marks.wave_sig))
      else $error("sync pin affected by polarity");

   // Inverted channel still gives the waveform sync uninverted
   a_inv_sync_wave: assert property ( // R5
      (!sync_off && pol_invert && sync_mode == ogs_pkg::OGS_SYNC_RAW
       && !cond.burst_on && !cond.sweep_on)
      |=> sync_pin_r == $past(marks.wave_sig))
      else $error("inverted channel inverted the sync pin");

   // Normal mode with burst running follows the burst envelope
   a_norm_burst: assert property ( // R7
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_NORMAL && cond.burst_on)
      |=> sync_pin_r == $past(marks.burst_env))
      else $error("normal sync ignores burst envelope");

   // Normal mode, internal modulation only: follows the modulator
   a_norm_mod: assert property ( // R7
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_NORMAL
       && !cond.burst_on && !cond.sweep_on && cond.mod_on && !cond.mod_ext)
      |=> sync_pin_r == $past(marks.mod_sig))
      else $error("normal sync ignores modulator");

   // Normal mode with sweep only follows the sweep envelope
   a_norm_sweep: assert property ( // R7
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_NORMAL
       && !cond.burst_on && cond.sweep_on)
      |=> sync_pin_r == $past(marks.sweep_env))
      else $error("normal sync ignores sweep envelope");

   // Normal mode with nothing else running follows the waveform
   a_norm_wave: assert property ( // R7
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_NORMAL
       && !cond.burst_on && !cond.sweep_on
       && !(cond.mod_on && !cond.mod_ext))
      |=> sync_pin_r == $past(marks.wave_sig))
      else $error("normal sync ignores waveform");

   // The spare mode code behaves as the normal mode
   a_norm_spare_code: assert property ( // R7
      (!sync_off && sync_mode == ogs_pkg::ogs_sync_mode_t'(2'h3)
       && cond.burst_on)
      |=> sync_pin_r == $past(marks.burst_env))
      else $error("spare sync code not treated as normal");

   // Raw mode with user table under burst or sweep: flag sample
   a_raw_flag: assert property ( // R8
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_RAW
       && (cond.burst_on || cond.sweep_on) && cond.wave_user)
      |=> sync_pin_r == $past(marks.flag_sample))
      else $error("raw sync misses flag sample");

   // Raw mode, burst without user table: waveform inside the burst
   a_raw_burst: assert property ( // R9
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_RAW
       && cond.burst_on && !cond.wave_user)
      |=> sync_pin_r == ($past(marks.wave_sig) && $past(marks.burst_env)))
      else $error("raw sync wrong during burst");

   // Raw mode outside burst and table sweep follows the waveform
   a_raw_wave: assert property ( // R9
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_RAW
       && !cond.burst_on && !(cond.sweep_on && cond.wave_user))
      |=> sync_pin_r == $past(marks.wave_sig))
      else $error("raw sync does not follow waveform");

   // Flag mode, plain run from a user table: flag sample
   a_flag_sample: assert property ( // R10
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && !cond.sweep_on
       && cond.unmodulated_run && cond.wave_user)
      |=> sync_pin_r == $past(marks.flag_sample))
      else $error("flag sync misses sample index");

   // Flag mode, internal modulation with any user table: flag sample
   a_flag_modint: assert property ( // R10
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && !cond.sweep_on && cond.mod_on && !cond.mod_ext
       && (cond.wave_user || cond.modsh_user))
      |=> sync_pin_r == $past(marks.flag_sample))
      else $error("flag sync misses sample under modulation");

   // Flag mode, external modulation of a user table: flag sample
   a_flag_extuser: assert property ( // R10
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && !cond.sweep_on && cond.mod_on && cond.mod_ext
       && cond.wave_user)
      |=> sync_pin_r == $past(marks.flag_sample))
      else $error("flag sync misses sample under external source");

   // Flag mode during burst marks the flag cycle
   a_flag_cycle: assert property ( // R11
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG && cond.burst_on)
      |=> sync_pin_r == $past(marks.flag_cycle))
      else $error("flag sync misses burst cycle");

   // Flag mode during sweep marks the flag frequency
   a_flag_freq: assert property ( // R12
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && cond.sweep_on)
      |=> sync_pin_r == $past(marks.flag_freq))
      else $error("flag sync misses sweep frequency");

   // Flag mode, external modulation, no user tables: modulator
   a_flag_modext: assert property ( // R13
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && !cond.sweep_on && cond.mod_on && cond.mod_ext
       && !cond.wave_user && !cond.modsh_user)
      |=> sync_pin_r == $past(marks.mod_sig))
      else $error("flag sync ignores external modulator");

   // External modulation with a user modulator shape only: waveform
   a_flag_extwave: assert property ( // R13
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && !cond.sweep_on && cond.mod_on && cond.mod_ext
       && !cond.wave_user && cond.modsh_user)
      |=> sync_pin_r == $past(marks.wave_sig))
      else $error("flag sync wrong for user modulator shape");

   // Flag mode with no table run and nothing active: waveform
   a_flag_plain: assert property ( // R13
      (!sync_off && sync_mode == ogs_pkg::OGS_SYNC_FLAG
       && !cond.burst_on && !cond.sweep_on && !cond.mod_on
       && !(cond.unmodulated_run && cond.wave_user))
      |=> sync_pin_r == $past(marks.wave_sig))
      else $error("flag sync does not fall back to waveform");

   // Sync pin only moves on a changed cause; it never flickers alone
   a_sync_steady: assert property ( // R14
      ($past(rst_n) && $stable(sync_nxt)) |=> $stable(sync_pin_r))
      else $error("sync pin changed without cause");

endmodule // ogs_output_gate

`default_nettype wire

// ### test/ogs_ext_equip.sv
// Model of the outside equipment: trigger source and sync listener
`timescale 1ns/1ps
`default_nettype none

module ogs_ext_equip (
   input wire logic arm,
   input wire logic sync_pin,
   output logic trig_pin,
   output int sync_edges
);
   // Trigger starts deasserted; no edges heard yet
   initial trig_pin = 1'b0;
   initial sync_edges = 0;

   // Trigger level lands off the clock grid, as a free source would
   always @(arm) trig_pin <= #1.3 arm;

   // Count sync rising edges, as equipment triggered by it would
   always @(posedge sync_pin) sync_edges++;
endmodule // ogs_ext_equip

`default_nettype wire

// ### test/ogs_output_gate_tb.sv
// Self-checking bench for the output gate and sync select
`timescale 1ns/1ps
`default_nettype none

module ogs_output_gate_tb;
   logic clk_sys = 1'b0; // System clock, 4 ns period
   logic rst_n = 1'b0; // Synchronous reset, active low
   logic arm = 1'b0; // Trigger request to the equipment model
   logic trig_pin;
   ogs_pkg::ogs_out_mode_t out_mode = ogs_pkg::OGS_OUT_NORMAL;
   logic pol_invert = 1'b0;
   logic sync_off = 1'b0; // Zero keeps sync enabled
   ogs_pkg::ogs_sync_mode_t sync_mode = ogs_pkg::OGS_SYNC_NORMAL;
   ogs_pkg::ogs_cond_t cond = '0;
   ogs_pkg::ogs_marks_t marks = '0;
   logic [15:0] wave_in = 16'h0000;
   logic [15:0] offset_in = 16'h0000;
   logic [15:0] chan_out_r;
   logic chan_route_r;
   logic sync_pin_r;
   int sync_edges; // Sync edges seen by the equipment
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0; // Hang guard; run needs about 1520 cycles

   ogs_output_gate u_ogs_output_gate (.clk_sys(clk_sys), .rst_n(rst_n),
      .trig_pin(trig_pin), .out_mode(out_mode), .pol_invert(pol_invert),
      .sync_off(sync_off), .sync_mode(sync_mode), .cond(cond),
      .marks(marks), .wave_in(wave_in), .offset_in(offset_in),
      .chan_out_r(chan_out_r), .chan_route_r(chan_route_r),
      .sync_pin_r(sync_pin_r));

   ogs_ext_equip u_ogs_ext_equip (.arm(arm), .sync_pin(sync_pin_r),
      .trig_pin(trig_pin), .sync_edges(sync_edges));

   // Clock generator
   always #2 clk_sys = ~clk_sys;

   // Cut a hang short
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         summarize();
      end
   end

   // Print counts and verdict, then stop
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Compare seen against expected with case equality
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Mirror about offset, clipped to the signed sample range
   function automatic logic [15:0] mir(logic [15:0] s, logic [15:0] o);
      logic signed [17:0] t;
      t = $signed({o[15], o, 1'b0}) - $signed({s[15], s[15], s});
      if (t > 18'sd32767) t = 18'sd32767;
      else if (t < -18'sd32768) t = -18'sd32768;
      return t[15:0];
   endfunction

   // Expected sync level per mode and operating conditions
   function automatic logic sel(ogs_pkg::ogs_sync_mode_t m,
      ogs_pkg::ogs_cond_t c, ogs_pkg::ogs_marks_t k);
      logic fs;
      logic me;
      me = c.mod_on & c.mod_ext;
      fs = (c.unmodulated_run & c.wave_user) | (me & c.wave_user) |
         (c.mod_on & !c.mod_ext & (c.wave_user | c.modsh_user));
      if (m == ogs_pkg::OGS_SYNC_RAW) begin
         if ((c.burst_on | c.sweep_on) & c.wave_user)
            return k.flag_sample;
         if (c.burst_on) return k.wave_sig & k.burst_env;
         return k.wave_sig;
      end
      if (m == ogs_pkg::OGS_SYNC_FLAG) begin
         if (c.burst_on) return k.flag_cycle;
         if (c.sweep_on) return k.flag_freq;
         if (fs) return k.flag_sample;
         if (me & !c.modsh_user) return k.mod_sig;
         return k.wave_sig;
      end
      // Unused code 3 behaves as the normal mode
      if (c.burst_on) return k.burst_env;
      if (c.sweep_on) return k.sweep_env;
      if (c.mod_on & !c.mod_ext) return k.mod_sig;
      return k.wave_sig;
   endfunction

   // Move the trigger, then let the synchroniser settle
   task automatic set_trig(input logic v);
      @(posedge clk_sys);
      arm <= v;
      repeat (4) @(posedge clk_sys);
   endtask

   // One vector: drive at an edge, check one cycle later
   task automatic vec(input logic [15:0] w, input logic [15:0] o,
      input logic p, input logic gm);
      logic route;
      logic sx;
      @(posedge clk_sys);
      wave_in <= w;
      offset_in <= o;
      pol_invert <= p;
      out_mode <= ogs_pkg::ogs_out_mode_t'(gm);
      sync_off <= ($urandom % 4) == 0;
      sync_mode <= ogs_pkg::ogs_sync_mode_t'(2'($urandom));
      cond <= 7'($urandom);
      marks <= 7'($urandom);
      @(posedge clk_sys);
      #1;
      route = (out_mode == ogs_pkg::OGS_OUT_NORMAL) | trig_pin;
      sx = !sync_off && sel(sync_mode, cond, marks);
      check(16'(chan_route_r), 16'(route));
      check(chan_out_r, !route ? offset_in : p ? mir(w, o) : w);
      check(16'(sync_pin_r), 16'(sx));
   endtask

   // Zero outputs while reset is held
   task automatic reset_zero();
      #1;
      check(chan_out_r, 16'h0000);
      check(16'(chan_route_r), 16'h0000);
      check(16'(sync_pin_r), 16'h0000);
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'hd95f));
      repeat (5) @(posedge clk_sys);
      reset_zero();
      @(posedge clk_sys);
      rst_n <= 1'b1;
      // Saturation ends and a plain mirror about zero
      vec(16'h8000, 16'h7fff, 1'b1, 1'b0);
      vec(16'h7fff, 16'h8000, 1'b1, 1'b0);
      vec(16'h1234, 16'h0000, 1'b1, 1'b0);
      // Sample at the offset level: inversion leaves it in place
      vec(16'h0100, 16'h0100, 1'b1, 1'b0);
      // Second reset in mid-run
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_zero();
      @(posedge clk_sys);
      rst_n <= 1'b1;
      // Random traffic; trigger toggles between blocks, gate reopens
      for (int b = 0; b < 12; b++) begin
         set_trig(b[0]);
         repeat (60) vec(16'($urandom), 16'($urandom),
            1'($urandom), 1'($urandom));
      end
      check(16'(sync_edges > 0), 16'h0001);
      summarize();
   end
endmodule // ogs_output_gate_tb

`default_nettype wire
